/* File: src/dual_timer.sv */
// dual sixteen-bit timer/event counter with apb register access
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "dual_timer_cfg.svh"
// Operation
// - two identical independent timer instances
// - interval, event count and pulse output modes
// - counter, comparator, registers, capture, two toggles
// - internal clocks tap a shared nine-bit prescaler
// - mode field selects tap or external pin
// - counter overflow raises overflow request
// - reset clears run control, stopping everything
// - run bit zero stops and clears counter
// - match on either compare register detected
// - compare registers are write-only, read zero
// - duty compare has a buffer register
// - per-timer double buffer enable bit
// - buffer loads duty compare on period match
// - reset clears buffer control register
// - buffering off: write updates register and buffer
// - buffering on: write updates buffer only
// - counter clears on period match when enabled
// - clear-on-match bit zero disables clearing
// - match raises match-detect and match request
module dual_timer (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    input wire logic i_ext_clock_in_first,
    input wire logic i_ext_clock_in_second,
    output logic o_pready,
    output logic o_pslverr,
    output logic [31:0] o_prdata,
    output logic o_overflow_irq_first,
    output logic o_overflow_irq_second,
    output logic o_match_irq_duty_first,
    output logic o_match_irq_period_first,
    output logic o_match_irq_duty_second,
    output logic o_match_irq_period_second,
    output logic o_toggle_ff_first_a,
    output logic o_toggle_ff_first_b,
    output logic o_toggle_ff_second_a,
    output logic o_toggle_ff_second_b
);
    localparam int NCH = 2;
    localparam int PW = `PRESCALE_WIDTH;
    logic [7:0] run_control_reg_q;
    logic [7:0] buffer_control_reg_q;
    logic [7:0] mode_q [NCH];
    logic [PW-1:0] prescale_q;
    logic [PW-1:0] prescale_d;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [NCH-1:0] ovf_q;
    logic [NCH-1:0] dmatch_q;
    logic [NCH-1:0] pmatch_q;
    logic [NCH-1:0] ffa_q;
    logic [NCH-1:0] ffb_q;
    logic [NCH-1:0] ext_rise;
    logic [NCH-1:0] ext_pin;
    logic [NCH-1:0] tick;
    logic [NCH-1:0] ovf;
    logic [NCH-1:0] dmatch;
    logic [NCH-1:0] pmatch;
    logic [NCH-1:0] ffa;
    logic [NCH-1:0] ffb;
    logic [15:0] count [NCH];
    logic [15:0] capture [NCH];
    logic prescale_tap_fine;
    logic prescale_tap_mid;
    logic prescale_tap_coarse;
    logic [31:0] rd_mux;
    logic rd_hit;

    // apb access phase decode; slave answers in the second access cycle, after one wait state
    wire access = i_psel && i_penable && !pready_q;
    wire wr_en = access && i_pwrite;
    wire rd_en = access && !i_pwrite;
    wire prescaler_run_bit = run_control_reg_q[`PRESCALER_RUN_BIT];
    wire [NCH-1:0] run_bits = {run_control_reg_q[`RUN_SECOND_BIT],
                               run_control_reg_q[`RUN_FIRST_BIT]};
    wire [NCH-1:0] dbuf_bits = {buffer_control_reg_q[`DBUF_SECOND_BIT],
                                buffer_control_reg_q[`DBUF_FIRST_BIT]};
    wire dbuf_enable_first = dbuf_bits[0];
    wire dbuf_enable_second = dbuf_bits[1];
    wire [11:0] duty_ofs [NCH] = '{`OFS_DUTY_FIRST, `OFS_DUTY_SECOND};
    wire [11:0] period_ofs [NCH] = '{`OFS_PERIOD_FIRST, `OFS_PERIOD_SECOND};
    wire [11:0] mode_ofs [NCH] = '{`OFS_MODE_FIRST, `OFS_MODE_SECOND};
    wire [11:0] toggle_ofs [NCH] = '{`OFS_TOGGLE_FIRST, `OFS_TOGGLE_SECOND};

    // shared nine-bit prescaler, stopped and cleared while its run bit is low
    always_comb begin
        prescale_d = prescaler_run_bit ? prescale_q + 1'b1 : '0;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            prescale_q <= '0;
        end else begin
            prescale_q <= prescale_d;
        end
    end

    // taps pulse once per period of 2, 8 and 32 system clocks
    assign prescale_tap_fine = prescaler_run_bit && (&prescale_q[`TAP_FINE_BIT:0]);
    assign prescale_tap_mid = prescaler_run_bit && (&prescale_q[`TAP_MID_BIT:0]);
    assign prescale_tap_coarse = prescaler_run_bit && (&prescale_q[`TAP_COARSE_BIT:0]);

    // control registers, cleared by reset
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            run_control_reg_q <= `RUN_RESET;
            buffer_control_reg_q <= `BUFCTRL_RESET;
        end else if (wr_en && i_pstrb[0]) begin
            if (i_paddr == `OFS_RUN_CONTROL) begin
                run_control_reg_q <= i_pwdata[7:0];
            end
            if (i_paddr == `OFS_BUFFER_CONTROL) begin
                buffer_control_reg_q <= i_pwdata[7:0];
            end
        end
    end

    // per-channel mode register, pin sync, clock select and timer core
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            wire dbuf_en = (g == 0) ? dbuf_enable_first : dbuf_enable_second;
            wire mode_wr = wr_en && i_pstrb[0] && (i_paddr == mode_ofs[g]);
            wire ff_wr = wr_en && i_pstrb[0] && (i_paddr == toggle_ofs[g]);
            wire duty_wr = wr_en && (i_paddr == duty_ofs[g]);
            wire period_wr = wr_en && (i_paddr == period_ofs[g]);
            wire cap_req = mode_wr && !i_pwdata[`MODE_CAPSW_BIT];
            wire [1:0] clk_field = mode_q[g][`MODE_CLK_LSB +: 2];

            always_ff @(posedge i_ref_clk) begin
                if (i_rst) begin
                    mode_q[g] <= `MODE_RESET;
                end else if (mode_wr) begin
                    mode_q[g] <= i_pwdata[7:0];
                end
            end

            pin_sync u_sync (
                .i_ref_clk(i_ref_clk),
                .i_rst(i_rst),
                .i_pin(ext_pin[g]),
                .o_level(),
                .o_rise(ext_rise[g])
            );

            // increment source from a tap or the external pin edge
            always_comb begin
                case (dual_timer_pkg::clk_sel_e'(clk_field))
                    dual_timer_pkg::CLK_EXTERNAL: tick[g] = ext_rise[g];
                    dual_timer_pkg::CLK_TAP_FINE: tick[g] = prescale_tap_fine;
                    dual_timer_pkg::CLK_TAP_MID: tick[g] = prescale_tap_mid;
                    dual_timer_pkg::CLK_TAP_COARSE: tick[g] = prescale_tap_coarse;
                    default: tick[g] = 1'b0;
                endcase
            end

            timer_channel #(
                .WIDTH(16)
            ) u_ch (
                .i_ref_clk(i_ref_clk),
                .i_rst(i_rst),
                .i_run(run_bits[g]),
                .i_tick(tick[g]),
                .i_clear_on_match(mode_q[g][`MODE_CLE_BIT]),
                .i_dbuf_en(dbuf_en),
                .i_duty_wr(duty_wr),
                .i_period_wr(period_wr),
                .i_wdata(i_pwdata[15:0]),
                .i_wstrb(i_pstrb),
                .i_capture_req(cap_req),
                .i_ff_wr(ff_wr),
                .i_ff_a_cmd(dual_timer_pkg::ff_cmd_e'(i_pwdata[1:0])),
                .i_ff_b_cmd(dual_timer_pkg::ff_cmd_e'(i_pwdata[3:2])),
                .o_count(count[g]),
                .o_capture(capture[g]),
                .o_overflow(ovf[g]),
                .o_duty_match(dmatch[g]),
                .o_period_match(pmatch[g]),
                .o_ff_a(ffa[g]),
                .o_ff_b(ffb[g])
            );
        end
    endgenerate

    assign ext_pin = {i_ext_clock_in_second, i_ext_clock_in_first};

    // read selection; compare registers are not on the read path so read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (i_paddr)
            `OFS_RUN_CONTROL: rd_mux = {24'h00_0000, run_control_reg_q};
            `OFS_BUFFER_CONTROL: rd_mux = {24'h00_0000, buffer_control_reg_q};
            `OFS_MODE_FIRST: rd_mux = {24'h00_0000, mode_q[0]};
            `OFS_MODE_SECOND: rd_mux = {24'h00_0000, mode_q[1]};
            `OFS_STATUS: rd_mux = {24'h00_0000, ffb_q, ffa_q, pmatch_q, dmatch_q};
            `OFS_COUNT_FIRST: rd_mux = {16'h0000, count[0]};
            `OFS_COUNT_SECOND: rd_mux = {16'h0000, count[1]};
            `OFS_CAPTURE_FIRST: rd_mux = {16'h0000, capture[0]};
            `OFS_CAPTURE_SECOND: rd_mux = {16'h0000, capture[1]};
            `OFS_TOGGLE_FIRST, `OFS_TOGGLE_SECOND: rd_mux = 32'h0000_0000;
            `OFS_DUTY_FIRST, `OFS_PERIOD_FIRST: rd_mux = 32'h0000_0000;
            `OFS_DUTY_SECOND, `OFS_PERIOD_SECOND: rd_mux = 32'h0000_0000;
            default: rd_hit = 1'b0;
        endcase
    end

    // apb answer registers
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= access;
            pslverr_q <= access && !rd_hit;
            prdata_q <= rd_en ? rd_mux : 32'h0000_0000;
        end
    end

    // registered event and toggle outputs
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            ovf_q <= '0;
            dmatch_q <= '0;
            pmatch_q <= '0;
            ffa_q <= '0;
            ffb_q <= '0;
        end else begin
            ovf_q <= ovf;
            dmatch_q <= dmatch;
            pmatch_q <= pmatch;
            ffa_q <= ffa;
            ffb_q <= ffb;
        end
    end

    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_prdata = prdata_q;
    assign o_overflow_irq_first = ovf_q[0];
    assign o_overflow_irq_second = ovf_q[1];
    assign o_match_irq_duty_first = dmatch_q[0];
    assign o_match_irq_period_first = pmatch_q[0];
    assign o_match_irq_duty_second = dmatch_q[1];
    assign o_match_irq_period_second = pmatch_q[1];
    assign o_toggle_ff_first_a = ffa_q[0];
    assign o_toggle_ff_first_b = ffb_q[0];
    assign o_toggle_ff_second_a = ffa_q[1];
    assign o_toggle_ff_second_b = ffb_q[1];
endmodule // dual_timer

/* File: src/dual_timer_cfg.svh */
// register offsets, field positions, reset values and prescaler taps for the dual timer
`ifndef DUAL_TIMER_CFG_SVH
`define DUAL_TIMER_CFG_SVH
`define OFS_RUN_CONTROL 12'h000
`define OFS_BUFFER_CONTROL 12'h004
`define OFS_MODE_FIRST 12'h008
`define OFS_MODE_SECOND 12'h00c
`define OFS_TOGGLE_FIRST 12'h010
`define OFS_TOGGLE_SECOND 12'h014
`define OFS_DUTY_FIRST 12'h018
`define OFS_PERIOD_FIRST 12'h01c
`define OFS_DUTY_SECOND 12'h020
`define OFS_PERIOD_SECOND 12'h024
`define OFS_STATUS 12'h028
`define OFS_COUNT_FIRST 12'h02c
`define OFS_COUNT_SECOND 12'h030
`define OFS_CAPTURE_FIRST 12'h034
`define OFS_CAPTURE_SECOND 12'h038
`define RUN_FIRST_BIT 0
`define RUN_SECOND_BIT 1
`define PRESCALER_RUN_BIT 7
`define DBUF_FIRST_BIT 0
`define DBUF_SECOND_BIT 1
`define MODE_CLK_LSB 0
`define MODE_CLE_BIT 2
`define MODE_CAPSW_BIT 3
`define RUN_RESET 8'h00
`define BUFCTRL_RESET 8'h00
`define MODE_RESET 8'h00
`define PRESCALE_WIDTH 9
`define TAP_FINE_BIT 0
`define TAP_MID_BIT 2
`define TAP_COARSE_BIT 4
`endif

/* File: src/dual_timer_pkg.sv */
// types shared by the dual timer files
package dual_timer_pkg;
    typedef enum logic [1:0] {
        CLK_EXTERNAL,
        CLK_TAP_FINE,
        CLK_TAP_MID,
        CLK_TAP_COARSE
    } clk_sel_e;
    typedef enum logic [1:0] {
        FF_SW_INVERT,
        FF_SW_CLEAR,
        FF_SW_SET,
        FF_SW_KEEP
    } ff_cmd_e;
endpackage

/* File: src/pin_sync.sv */
// three-stage synchroniser with edge detection for an external pin
`timescale 1ns/1ps
module pin_sync (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_pin,
    output logic o_level,
    output logic o_rise
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;
    // second and third stage must agree before the level moves
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level_q <= 1'b0;
        end else begin
            s1_q <= i_pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_q <= s3_q;
            end
        end
    end
    // rising edge of the agreed level
    assign o_rise = (s2_q == s3_q) && s3_q && !level_q;
    assign o_level = level_q;
endmodule // pin_sync

/* File: src/timer_channel.sv */
// one sixteen-bit timer channel: counter, compares, double buffer, toggles
`timescale 1ns/1ps
`include "dual_timer_cfg.svh"
module timer_channel #(
    parameter int WIDTH = 16
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_run,
    input wire logic i_tick,
    input wire logic i_clear_on_match,
    input wire logic i_dbuf_en,
    input wire logic i_duty_wr,
    input wire logic i_period_wr,
    input wire logic [WIDTH-1:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_capture_req,
    input wire logic i_ff_wr,
    input wire dual_timer_pkg::ff_cmd_e i_ff_a_cmd,
    input wire dual_timer_pkg::ff_cmd_e i_ff_b_cmd,
    output logic [WIDTH-1:0] o_count,
    output logic [WIDTH-1:0] o_capture,
    output logic o_overflow,
    output logic o_duty_match,
    output logic o_period_match,
    output logic o_ff_a,
    output logic o_ff_b
);
    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] duty_q;
    logic [WIDTH-1:0] duty_buf_q;
    logic [WIDTH-1:0] period_q;
    logic [WIDTH-1:0] capture_q;
    logic ff_a_q;
    logic ff_b_q;
    logic [WIDTH-1:0] wr_merged_duty;
    logic [WIDTH-1:0] wr_merged_period;
    wire duty_hit = i_run && (count_q == duty_q);
    wire period_hit = i_run && (count_q == period_q);
    wire step = i_run && i_tick;
    wire wrap = step && (count_q == {WIDTH{1'b1}});
    wire clear_hit = step && period_hit && i_clear_on_match;
    // byte lanes let software write the low byte and then the high byte
    always_comb begin
        wr_merged_duty = duty_buf_q;
        wr_merged_period = period_q;
        if (i_wstrb[0]) begin
            wr_merged_duty[7:0] = i_wdata[7:0];
            wr_merged_period[7:0] = i_wdata[7:0];
        end
        if (i_wstrb[1]) begin
            wr_merged_duty[WIDTH-1:8] = i_wdata[WIDTH-1:8];
            wr_merged_period[WIDTH-1:8] = i_wdata[WIDTH-1:8];
        end
    end
    // up-counter: stop and clear when not running, wrap on overflow
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || !i_run) begin
            count_q <= '0;
        end else if (clear_hit) begin
            count_q <= '0;
        end else if (step) begin
            count_q <= count_q + 1'b1;
        end
    end
    // compare registers with double-buffered duty value
    always_ff @(posedge i_ref_clk) begin
        if (i_duty_wr) begin
            duty_buf_q <= wr_merged_duty;
            if (!i_dbuf_en) begin
                duty_q <= wr_merged_duty;
            end
        end else if (i_dbuf_en && step && period_hit) begin
            duty_q <= duty_buf_q;
        end
        if (i_period_wr) begin
            period_q <= wr_merged_period;
        end
    end
    // software capture and the two output toggles
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            capture_q <= '0;
            ff_a_q <= 1'b0;
            ff_b_q <= 1'b0;
        end else begin
            if (i_capture_req) begin
                capture_q <= count_q;
            end
            if (i_ff_wr && i_ff_a_cmd != dual_timer_pkg::FF_SW_KEEP) begin
                ff_a_q <= (i_ff_a_cmd == dual_timer_pkg::FF_SW_INVERT) ? !ff_a_q :
                          (i_ff_a_cmd == dual_timer_pkg::FF_SW_SET);
            end else if (step && (duty_hit || period_hit)) begin
                ff_a_q <= !ff_a_q;
            end
            if (i_ff_wr && i_ff_b_cmd != dual_timer_pkg::FF_SW_KEEP) begin
                ff_b_q <= (i_ff_b_cmd == dual_timer_pkg::FF_SW_INVERT) ? !ff_b_q :
                          (i_ff_b_cmd == dual_timer_pkg::FF_SW_SET);
            end else if (step && period_hit) begin
                ff_b_q <= !ff_b_q;
            end
        end
    end
    assign o_count = count_q;
    assign o_capture = capture_q;
    assign o_overflow = wrap;
    assign o_duty_match = step && duty_hit;
    assign o_period_match = step && period_hit;
    assign o_ff_a = ff_a_q;
    assign o_ff_b = ff_b_q;
    initial begin
        if (WIDTH != 16) begin
            $error("timer_channel supports only WIDTH 16");
        end
    end
endmodule // timer_channel

/* File: test/dual_timer_asserts.sv */
// concurrent checks on the dual timer ports, bound to the design
`timescale 1ns/1ps
module dual_timer_asserts (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic [31:0] o_prdata,
    input wire logic o_overflow_irq_first,
    input wire logic o_overflow_irq_second,
    input wire logic o_match_irq_duty_first,
    input wire logic o_match_irq_period_first,
    input wire logic o_match_irq_duty_second
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    logic irq_any;
    // any request line high except the second period match request
    assign irq_any = o_overflow_irq_first | o_overflow_irq_second | o_match_irq_duty_first
        | o_match_irq_period_first | o_match_irq_duty_second;
    AST_RST_QUIET: assert property ($fell(i_rst) |-> !irq_any && !o_pready)
        else $error("request active right after reset");
    AST_CMP_READ_ZERO: assert property (o_pready && !i_pwrite &&
        i_paddr inside {12'h018, 12'h01c, 12'h020, 12'h024} |-> o_prdata == 32'h0)
        else $error("compare register read returned data");
    AST_PERIOD_PULSE: assert property (o_match_irq_period_first |=> !o_match_irq_period_first)
        else $error("period match request longer than one cycle");
    AST_DUTY_PULSE_SECOND: assert property (o_match_irq_duty_second |=> !o_match_irq_duty_second)
        else $error("second duty match request longer than one cycle");
    AST_OVF_PULSE: assert property (o_overflow_irq_first |=> !o_overflow_irq_first)
        else $error("overflow request longer than one cycle");
    AST_PREADY_TIMING: assert property (i_psel && $rose(i_penable) |=> o_pready)
        else $error("ready not one cycle into access phase");
    AST_ERR_WITH_READY: assert property (o_pslverr |-> o_pready)
        else $error("slave error without ready");
    AST_IDLE_RDATA: assert property (!o_pready |-> o_prdata == 32'h0)
        else $error("read data not zero outside answer");
    COV_PERIOD: cover property (o_match_irq_period_first);
    COV_DUTY_SECOND: cover property (o_match_irq_duty_second);
    COV_ERR: cover property (o_pslverr);
endmodule // dual_timer_asserts
bind dual_timer dual_timer_asserts u_dual_timer_asserts (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_prdata(o_prdata),
    .o_overflow_irq_first(o_overflow_irq_first), .o_overflow_irq_second(o_overflow_irq_second),
    .o_match_irq_duty_first(o_match_irq_duty_first),
    .o_match_irq_period_first(o_match_irq_period_first),
    .o_match_irq_duty_second(o_match_irq_duty_second));

/* File: test/ext_event_model.sv */
// external event source driving the two timer clock pins
`timescale 1ns/1ps
module ext_event_model (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_fire,
    input wire logic i_which,
    output logic o_ext_clock_in_first,
    output logic o_ext_clock_in_second
);
    logic [3:0] span_q = 4'h0;
    logic which_q = 1'b0;
    logic pulse;
    // one event is six cycles high then six low, so the pin filter sees it
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            span_q <= 4'h0;
        end else if (i_fire) begin
            span_q <= 4'hc;
            which_q <= i_which;
        end else if (span_q != 4'h0) begin
            span_q <= span_q - 4'h1;
        end
    end
    // idle pins rest low between events
    assign pulse = span_q > 4'h6;
    assign o_ext_clock_in_first = pulse && !which_q;
    assign o_ext_clock_in_second = pulse && which_q;
endmodule // ext_event_model

/* File: test/testbench.sv */
// self-checking bench for the dual timer
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rdv, prdata;
    logic [3:0] pstrb = 4'h0;
    logic fire = 1'b0, which = 1'b0, pin_a, pin_b, pready, pslverr, erv, pm, dm, pm2;
    int pm2_n = 0;
    logic [3:0] ff;
    int n_mismatch = 0, total_checks = 0, since_p = 0, per_gap = 0, duty_gap = 0, d0, a;
    always #25 clk = ~clk;
    dual_timer u_dual_timer (.i_ref_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
        .i_ext_clock_in_first(pin_a), .i_ext_clock_in_second(pin_b), .o_pready(pready),
        .o_pslverr(pslverr), .o_prdata(prdata), .o_overflow_irq_first(),
        .o_overflow_irq_second(), .o_match_irq_duty_first(dm), .o_match_irq_period_first(pm),
        .o_match_irq_duty_second(), .o_match_irq_period_second(pm2),
        .o_toggle_ff_first_a(ff[0]), .o_toggle_ff_first_b(ff[1]),
        .o_toggle_ff_second_a(ff[2]), .o_toggle_ff_second_b(ff[3]));
    ext_event_model u_ext_event_model (.i_ref_clk(clk), .i_rst(rst), .i_fire(fire),
        .i_which(which), .o_ext_clock_in_first(pin_a), .o_ext_clock_in_second(pin_b));
    // cycles from a period match to the next period and duty matches
    always @(posedge clk) begin
        since_p <= since_p + 1;
        if (dm === 1'b1) duty_gap <= since_p + 1;
        if (pm2 === 1'b1) pm2_n <= pm2_n + 1;
        if (pm === 1'b1) begin
            per_gap <= since_p + 1;
            since_p <= 0;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one apb transfer, held until ready is sampled high
    task automatic apb(input logic [11:0] ad, input logic w, input logic [31:0] d,
        input logic [3:0] s);
        int n;
        n = 0;
        psel <= 1'b1; penable <= 1'b0; paddr <= ad; pwrite <= w; pwdata <= d; pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        // one idle edge so the next setup never reassigns psel in this step
        @(posedge clk);
        if (n >= 20) n_mismatch++;
    endtask
    task automatic wr(input logic [11:0] ad, input logic [31:0] d, input logic [3:0] s);
        apb(ad, 1'b1, d, s);
    endtask
    task automatic rd(input logic [11:0] ad);
        apb(ad, 1'b0, 32'h0, 4'h0);
    endtask
    // wait for a period (0) or duty (1) match of the first timer, then one more edge
    task automatic wait_m(input bit duty);
        int n;
        n = 0;
        do @(posedge clk); while ((duty ? dm : pm) !== 1'b1 && ++n < 2000);
        if (n >= 2000) n_mismatch++;
        @(posedge clk);
    endtask
    task automatic test_reset;
        rd(12'h000); chk(rdv, 32'h0);
        rd(12'h004); chk(rdv, 32'h0);
        wr(12'h018, 32'h1234, 4'h3);
        rd(12'h018); chk(rdv, 32'h0);
        rd(12'h040); chk({31'h0, erv}, 32'h1);
        $display("test_reset done");
    endtask
    task automatic test_taps;
        wr(12'h01c, 32'h5, 4'h1);
        wr(12'h01c, 32'h0, 4'h2);
        for (int sel = 1; sel <= 3; sel++) begin
            wr(12'h000, 32'h80, 4'h1);
            wr(12'h008, 32'hc | sel, 4'h1);
            wr(12'h000, 32'h81, 4'h1);
            wait_m(0);
            wait_m(0);
            chk(per_gap, 6 * (2 << (2 * (sel - 1))));
        end
        wr(12'h008, 32'h09, 4'h1);
        repeat (40) @(posedge clk);
        rd(12'h02c); chk(rdv > 32'h5, 32'h1);
        a = rdv;
        repeat (16) @(posedge clk);
        rd(12'h02c); chk(rdv - a, 32'ha);
        wr(12'h000, 32'h80, 4'h1);
        rd(12'h02c); chk(rdv, 32'h0);
        wr(12'h000, 32'h01, 4'h1);
        repeat (20) @(posedge clk);
        rd(12'h02c); chk(rdv, 32'h0);
        $display("test_taps done");
    endtask
    task automatic test_ext;
        wr(12'h000, 32'h80, 4'h1);
        wr(12'h008, 32'h0c, 4'h1);
        wr(12'h000, 32'h81, 4'h1);
        for (int i = 0; i < 4; i++) begin
            fire <= 1'b1; which <= (i == 3);
            @(posedge clk);
            fire <= 1'b0;
            repeat (14) @(posedge clk);
        end
        rd(12'h02c); chk(rdv, 32'h3);
        $display("test_ext done");
    endtask
    task automatic test_dbuf;
        wr(12'h000, 32'h80, 4'h1);
        wr(12'h01c, 32'h9, 4'h3);
        wr(12'h018, 32'h3, 4'h3);
        wr(12'h008, 32'h0d, 4'h1);
        wr(12'h000, 32'h81, 4'h1);
        wait_m(1); wait_m(1);
        d0 = duty_gap;
        wr(12'h018, 32'h4, 4'h3);
        wait_m(0); wait_m(1); chk(duty_gap, d0 + 2);
        wr(12'h004, 32'h1, 4'h1);
        rd(12'h004); chk(rdv, 32'h1);
        wait_m(0); wait_m(1); chk(duty_gap, d0 + 2);
        wait_m(0);
        wr(12'h018, 32'h6, 4'h3);
        wait_m(1); chk(duty_gap, d0 + 2);
        wait_m(0); wait_m(1); chk(duty_gap, d0 + 6);
        $display("test_dbuf done");
    endtask
    task automatic test_misc;
        wr(12'h000, 32'h80, 4'h1);
        wr(12'h010, 32'h06, 4'h1);
        repeat (3) @(posedge clk);
        chk(ff[1:0], 2'b01);
        wr(12'h010, 32'h09, 4'h1);
        repeat (3) @(posedge clk);
        chk(ff[1:0], 2'b10);
        wr(12'h024, 32'h20, 4'h3);
        wr(12'h020, 32'h10, 4'h3);
        wr(12'h00c, 32'h0d, 4'h1);
        wr(12'h000, 32'h82, 4'h1);
        repeat (100) @(posedge clk);
        rd(12'h030); chk(rdv <= 32'h20, 32'h1);
        chk(pm2_n > 0, 32'h1);
        rd(12'h02c); chk(rdv, 32'h0);
        $display("test_misc done");
    endtask
    task automatic print_verdict;
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // watchdog against a hung wait
    initial begin
        #3000000;
        n_mismatch++;
        print_verdict;
    end
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        test_reset;
        test_taps;
        test_ext;
        test_dbuf;
        test_misc;
        print_verdict;
    end
endmodule // testbench
